//--- src/sgsw_selector.sv
// Gain set selector of the position loop with an AXI4-Lite register slave
//
// The implementer's own choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps

// Functional notes
// - Mode 5: speed command switches, delayed return
// - Mode 6: deviation switches, delayed return
// - Deviation in encoder or scale counts
// - Mode 7: nonzero position command selects second
// - Mode 8: incomplete positioning selects second
// - Mode 9: actual speed switches, delayed return
// - Mode 10: command up, return needs slow speed
// - Return delay 0..10000 ticks, default 10
// - Trigger level 0..20000
// - Trigger hysteresis 0..20000, default zero
// - Hysteresis above level is clipped to level
// - Mode 3: torque command switches, delayed return
// - Mode 0 fixes first, mode 1 second
// - Mode 2 follows gain input if allocated
module sgsw_selector
  import sgsw_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire logic        ce_i,
  input  wire sgsw_loop_t  loop_i,
  input  wire sgsw_ctl_t   ctl_mode_i,
  input  wire logic        gain_in_i,
  output logic             second_gain_o,
  input  wire logic [7:0]  s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  output logic [1:0]       s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  input  wire logic [7:0]  s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i
);

  sgsw_state_t st_reg;
  sgsw_state_t st_next;

  logic        pos_ok;
  logic [14:0] hyst_eff;
  logic [15:0] thr_high;
  logic [14:0] thr_low;
  logic [31:0] dev_sel;
  logic        forced;
  sgsw_gain_t  forced_gain;
  logic        up_c;
  logic        dn_c;
  logic        do_write;
  logic        map_hit;

  // Magnitude as unsigned; the most negative value maps to its true size
  function automatic logic [31:0] mag32(input logic [31:0] v);
    mag32 = v[31] ? 32'(~v + 32'h0000_0001) : v;
  endfunction

  function automatic logic above(input logic [31:0] v, input logic [15:0] thr);
    above = mag32(v) > {16'h0000, thr};
  endfunction

  function automatic logic below(input logic [31:0] v, input logic [14:0] thr);
    below = mag32(v) < {17'h0_0000, thr};
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    merge = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        merge[8*i +: 8] = new_v[8*i +: 8];
      end
    end
  endfunction

  function automatic logic [31:0] read_word(input sgsw_state_t s, input logic [7:0] a,
                                            input logic dn);
    read_word = 32'h0000_0000;
    unique case (a)
      ADDR_CTRL: begin
        read_word[CTRL_MODE_LSB +: 4] = s.mode;
        read_word[CTRL_GAININ_BIT]    = s.gainin_en;
      end
      ADDR_DELAY:  read_word[13:0] = s.delay;
      ADDR_LEVEL:  read_word[14:0] = s.level;
      ADDR_HYST:   read_word[14:0] = s.hyst;
      ADDR_STATUS: begin
        read_word[STAT_GAIN_BIT]        = s.gain;
        read_word[STAT_RETURN_BIT]      = dn;
        read_word[STAT_DLY_LSB +: 14]   = s.dly_cnt;
      end
      default:     read_word = 32'h0000_0000;
    endcase
  endfunction

  function automatic logic known_addr(input logic [7:0] a);
    known_addr = (a == ADDR_CTRL) || (a == ADDR_DELAY) || (a == ADDR_LEVEL) ||
                 (a == ADDR_HYST) || (a == ADDR_STATUS);
  endfunction

  // Readies depend on ce_i so nothing is taken while the state is frozen
  assign s_axi_awready_o = ce_i && !st_reg.aw_seen && !st_reg.bvalid;
  assign s_axi_wready_o  = ce_i && !st_reg.w_seen && !st_reg.bvalid;
  assign s_axi_arready_o = ce_i && !st_reg.rvalid;
  assign s_axi_bvalid_o  = st_reg.bvalid;
  assign s_axi_bresp_o   = st_reg.bresp;
  assign s_axi_rvalid_o  = st_reg.rvalid;
  assign s_axi_rdata_o   = st_reg.rdata;
  assign s_axi_rresp_o   = st_reg.rresp;
  assign second_gain_o   = st_reg.gain;

  assign do_write = st_reg.aw_seen && st_reg.w_seen && !st_reg.bvalid;
  assign map_hit  = known_addr(st_reg.awaddr);

  // Trigger evaluation
  always_comb begin
    pos_ok   = (ctl_mode_i == SGSW_CTL_POS) || (ctl_mode_i == SGSW_CTL_FCL);
    hyst_eff = (st_reg.level < st_reg.hyst) ? st_reg.level : st_reg.hyst;
    thr_high = 16'({1'b0, st_reg.level} + {1'b0, hyst_eff});
    thr_low  = 15'(st_reg.level - hyst_eff);
    dev_sel  = (ctl_mode_i == SGSW_CTL_FCL) ? loop_i.dev_scale
                                            : loop_i.dev_encoder;
    forced      = 1'b0;
    forced_gain = SGSW_GAIN_FIRST;
    up_c        = 1'b0;
    dn_c        = 1'b0;
    case (st_reg.mode)
      SGSW_FIX_FIRST: begin
        forced = 1'b1;
      end
      SGSW_FIX_SECOND: begin
        forced      = 1'b1;
        forced_gain = SGSW_GAIN_SECOND;
      end
      SGSW_GAIN_INPUT: begin
        forced      = 1'b1;
        forced_gain = (gain_in_i && st_reg.gainin_en) ? SGSW_GAIN_SECOND
                                                      : SGSW_GAIN_FIRST;
      end
      SGSW_TORQUE: begin
        up_c = above(32'(loop_i.torque_cmd), thr_high);
        dn_c = below(32'(loop_i.torque_cmd), thr_low);
      end
      SGSW_SPEED_CMD: begin
        up_c = above(loop_i.speed_cmd, thr_high);
        dn_c = below(loop_i.speed_cmd, thr_low);
      end
      SGSW_DEVIATION: begin
        up_c = above(dev_sel, thr_high);
        dn_c = below(dev_sel, thr_low);
      end
      SGSW_POS_CMD: begin
        up_c = loop_i.pos_cmd != 32'h0000_0000;
        dn_c = !up_c;
      end
      SGSW_NOT_INPOS: begin
        up_c = !loop_i.inpos;
        dn_c = loop_i.inpos;
      end
      SGSW_SPEED_ACT: begin
        up_c = above(loop_i.speed_act, thr_high);
        dn_c = below(loop_i.speed_act, thr_low);
      end
      SGSW_CMD_SPEED: begin
        up_c = loop_i.pos_cmd != 32'h0000_0000;
        dn_c = !up_c && below(loop_i.speed_act, thr_low);
      end
      default: begin
        forced = 1'b1;
      end
    endcase
    // Load-dependent modes make no sense outside position-type control
    if (st_reg.mode >= 4'h5 && st_reg.mode <= 4'hA && !pos_ok) begin
      forced      = 1'b1;
      forced_gain = SGSW_GAIN_FIRST;
      up_c        = 1'b0;
      dn_c        = 1'b0;
    end
  end

  // Next state: bus slave and gain sequencer
  always_comb begin
    st_next = st_reg;
    // Write channel
    if (s_axi_awvalid_i && s_axi_awready_o) begin
      st_next.awaddr  = s_axi_awaddr_i;
      st_next.aw_seen = 1'b1;
    end
    if (s_axi_wvalid_i && s_axi_wready_o) begin
      st_next.wdata  = s_axi_wdata_i;
      st_next.wstrb  = s_axi_wstrb_i;
      st_next.w_seen = 1'b1;
    end
    if (do_write) begin
      st_next.aw_seen = 1'b0;
      st_next.w_seen  = 1'b0;
      st_next.bvalid  = 1'b1;
      st_next.bresp   = map_hit ? RESP_OKAY : RESP_SLVERR;
      unique case (st_reg.awaddr)
        ADDR_CTRL: begin
          st_next.mode      = 4'(merge(read_word(st_reg, ADDR_CTRL, dn_c), st_reg.wdata,
                                       st_reg.wstrb) >> CTRL_MODE_LSB);
          st_next.gainin_en = st_reg.wstrb[1] ? st_reg.wdata[CTRL_GAININ_BIT]
                                              : st_reg.gainin_en;
        end
        ADDR_DELAY: begin
          // Out-of-range values saturate rather than wrap
          st_next.delay = (merge({18'h0_0000, st_reg.delay}, st_reg.wdata, st_reg.wstrb)
                           > {18'h0_0000, DELAY_MAX}) ? DELAY_MAX
                          : 14'(merge({18'h0_0000, st_reg.delay}, st_reg.wdata,
                                      st_reg.wstrb));
        end
        ADDR_LEVEL: begin
          st_next.level = (merge({17'h0_0000, st_reg.level}, st_reg.wdata, st_reg.wstrb)
                           > {17'h0_0000, LEVEL_MAX}) ? LEVEL_MAX
                          : 15'(merge({17'h0_0000, st_reg.level}, st_reg.wdata,
                                      st_reg.wstrb));
        end
        ADDR_HYST: begin
          st_next.hyst = (merge({17'h0_0000, st_reg.hyst}, st_reg.wdata, st_reg.wstrb)
                          > {17'h0_0000, LEVEL_MAX}) ? LEVEL_MAX
                         : 15'(merge({17'h0_0000, st_reg.hyst}, st_reg.wdata,
                                     st_reg.wstrb));
        end
        default: begin
          st_next.bvalid = 1'b1;
        end
      endcase
    end
    if (st_reg.bvalid && s_axi_bready_i) begin
      st_next.bvalid = 1'b0;
    end
    // Read channel
    if (s_axi_arvalid_i && s_axi_arready_o) begin
      st_next.rvalid = 1'b1;
      st_next.rdata  = read_word(st_reg, s_axi_araddr_i, dn_c);
      st_next.rresp  = known_addr(s_axi_araddr_i) ? RESP_OKAY : RESP_SLVERR;
    end else if (st_reg.rvalid && s_axi_rready_i) begin
      st_next.rvalid = 1'b0;
    end
    // Gain sequencer
    if (forced) begin
      st_next.gain    = forced_gain;
      st_next.tick    = 12'h000;
      st_next.dly_cnt = 14'h0000;
    end else if (st_reg.gain == SGSW_GAIN_FIRST) begin
      st_next.tick    = 12'h000;
      st_next.dly_cnt = 14'h0000;
      if (up_c) begin
        st_next.gain = SGSW_GAIN_SECOND;
      end
    end else if (!dn_c) begin
      st_next.tick    = 12'h000;
      st_next.dly_cnt = 14'h0000;
    end else if (st_reg.dly_cnt >= st_reg.delay) begin
      st_next.gain    = SGSW_GAIN_FIRST;
      st_next.tick    = 12'h000;
      st_next.dly_cnt = 14'h0000;
    end else if (st_reg.tick == TICK_CYCLES - 12'h001) begin
      st_next.tick    = 12'h000;
      st_next.dly_cnt = st_reg.dly_cnt + 14'h0001;
    end else begin
      st_next.tick = st_reg.tick + 12'h001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      st_reg <= '{mode: MODE_RST, delay: DELAY_RST, level: LEVEL_RST, hyst: HYST_RST,
                  gain: SGSW_GAIN_FIRST, default: '0};
    end else if (ce_i) begin
      st_reg <= st_next;
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);

  fix_first_a: assert property (ce_i && st_reg.mode == 4'h0 |=> !second_gain_o)
    else $error("mode 0 did not hold the first gain");
  fix_second_a: assert property (ce_i && st_reg.mode == 4'h1 |=> second_gain_o)
    else $error("mode 1 did not hold the second gain");
  gain_input_a: assert property (ce_i && st_reg.mode == 4'h2
      |=> second_gain_o == $past(gain_in_i && st_reg.gainin_en))
    else $error("mode 2 did not follow the gain input");
  speed_up_a: assert property (ce_i && st_reg.mode == 4'h5 && pos_ok &&
      mag32(loop_i.speed_cmd) > {16'h0000, thr_high} |=> second_gain_o)
    else $error("speed command above threshold did not select second gain");
  scale_dev_a: assert property (ce_i && st_reg.mode == 4'h6 &&
      ctl_mode_i == SGSW_CTL_FCL && mag32(loop_i.dev_scale) > {16'h0000, thr_high}
      |=> second_gain_o)
    else $error("scale deviation did not select second gain");
  pos_cmd_up_a: assert property (ce_i && st_reg.mode == 4'h7 && pos_ok &&
      loop_i.pos_cmd != 32'h0000_0000 |=> second_gain_o)
    else $error("position command did not select second gain");
  inpos_up_a: assert property (ce_i && st_reg.mode == 4'h8 && pos_ok &&
      !loop_i.inpos |=> second_gain_o)
    else $error("incomplete positioning did not select second gain");
  invalid_ctl_a: assert property (ce_i && st_reg.mode >= 4'h5 &&
      st_reg.mode <= 4'hA && !pos_ok |=> !second_gain_o)
    else $error("load mode outside position control left second gain");
  delay_hold_a: assert property (ce_i && second_gain_o && !forced &&
      st_reg.dly_cnt < st_reg.delay |=> second_gain_o)
    else $error("second gain released before the delay elapsed");
  delay_restart_a: assert property (ce_i && second_gain_o && !forced && !dn_c
      |=> st_reg.dly_cnt == 14'h0000 && st_reg.tick == 12'h000)
    else $error("delay count not restarted on interrupted return");
  hyst_clip_a: assert property (hyst_eff <= st_reg.level &&
      st_reg.level <= LEVEL_MAX && st_reg.hyst <= LEVEL_MAX)
    else $error("effective hysteresis or settings out of range");
  delay_range_a: assert property (st_reg.delay <= DELAY_MAX)
    else $error("return delay out of range");
  torque_up_a: assert property (ce_i && st_reg.mode == SGSW_TORQUE &&
      mag32(32'(loop_i.torque_cmd)) > {16'h0000, thr_high} |=> second_gain_o)
    else $error("torque command above threshold did not select second gain");
  enc_dev_a: assert property (ce_i && st_reg.mode == SGSW_DEVIATION &&
      ctl_mode_i == SGSW_CTL_POS && mag32(loop_i.dev_encoder) > {16'h0000, thr_high}
      |=> second_gain_o)
    else $error("encoder deviation did not select second gain");
  act_speed_a: assert property (ce_i && st_reg.mode == SGSW_SPEED_ACT && pos_ok &&
      mag32(loop_i.speed_act) > {16'h0000, thr_high} |=> second_gain_o)
    else $error("actual speed above threshold did not select second gain");
  fast_axis_a: assert property (ce_i && st_reg.mode == SGSW_CMD_SPEED && pos_ok &&
      second_gain_o && mag32(loop_i.speed_act) >= {17'h0_0000, thr_low} |=> second_gain_o)
    else $error("second gain left while the axis was still fast");
  delay_done_a: assert property (ce_i && second_gain_o && !forced && dn_c &&
      st_reg.dly_cnt >= st_reg.delay |=> !second_gain_o)
    else $error("first gain not restored after the delay elapsed");
  tick_range_a: assert property (st_reg.tick < TICK_CYCLES)
    else $error("delay tick counter out of range");

endmodule

//--- src/sgsw_pkg.sv
// Constants, enumerations and carriers of the servo gain switch selector
package sgsw_pkg;

  // Timebase of the return delay: 0.1 ms steps on a 40 ns clock
  localparam real         TICK_PERIOD_MS = 0.1;
  localparam real         CLK_PERIOD_NS  = 40.0;
  localparam logic [11:0] TICK_CYCLES    =
    12'($rtoi(TICK_PERIOD_MS * 1.0E6 / CLK_PERIOD_NS + 1.0E-6));

  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_DELAY  = 8'h04;
  localparam logic [7:0] ADDR_LEVEL  = 8'h08;
  localparam logic [7:0] ADDR_HYST   = 8'h0C;
  localparam logic [7:0] ADDR_STATUS = 8'h10;

  // Field positions
  localparam int CTRL_MODE_LSB    = 0;
  localparam int CTRL_GAININ_BIT  = 8;
  localparam int STAT_GAIN_BIT    = 0;
  localparam int STAT_RETURN_BIT  = 1;
  localparam int STAT_DLY_LSB     = 16;

  // Reset values and ranges
  localparam logic [3:0]  MODE_RST  = 4'h0;
  localparam logic [13:0] DELAY_RST = 14'h000A;
  localparam logic [13:0] DELAY_MAX = 14'h2710;
  localparam logic [14:0] LEVEL_RST = 15'h0000;
  localparam logic [14:0] HYST_RST  = 15'h0000;
  localparam logic [14:0] LEVEL_MAX = 15'h4E20;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    SGSW_FIX_FIRST  = 4'h0,
    SGSW_FIX_SECOND = 4'h1,
    SGSW_GAIN_INPUT = 4'h2,
    SGSW_TORQUE     = 4'h3,
    SGSW_SPEED_CMD  = 4'h5,
    SGSW_DEVIATION  = 4'h6,
    SGSW_POS_CMD    = 4'h7,
    SGSW_NOT_INPOS  = 4'h8,
    SGSW_SPEED_ACT  = 4'h9,
    SGSW_CMD_SPEED  = 4'hA
  } sgsw_mode_t;

  typedef enum logic [1:0] {
    SGSW_CTL_POS = 2'h0,
    SGSW_CTL_VEL = 2'h1,
    SGSW_CTL_TRQ = 2'h2,
    SGSW_CTL_FCL = 2'h3
  } sgsw_ctl_t;

  typedef enum logic {
    SGSW_GAIN_FIRST  = 1'b0,
    SGSW_GAIN_SECOND = 1'b1
  } sgsw_gain_t;

  // Quantities from the control loops and the command path
  typedef struct packed {
    logic signed [15:0] torque_cmd;
    logic signed [31:0] speed_cmd;
    logic signed [31:0] speed_act;
    logic signed [31:0] dev_encoder;
    logic signed [31:0] dev_scale;
    logic signed [31:0] pos_cmd;
    logic               inpos;
  } sgsw_loop_t;

  typedef struct packed {
    logic [7:0]  awaddr;
    logic        aw_seen;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        w_seen;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [3:0]  mode;
    logic        gainin_en;
    logic [13:0] delay;
    logic [14:0] level;
    logic [14:0] hyst;
    sgsw_gain_t  gain;
    logic [11:0] tick;
    logic [13:0] dly_cnt;
  } sgsw_state_t;

endpackage

//--- sim/sgsw_loop_model.sv
// Behavioural model of the loop datapath and the position command source
`timescale 1ns/1ps
module sgsw_loop_model
  import sgsw_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  input  wire sgsw_loop_t target_i,
  output sgsw_loop_t      loop_o
);
  // One register stage, since loop quantities are sampled datapath values
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      loop_o <= '{inpos: 1'b1, default: '0};
    end else begin
      loop_o <= target_i;
    end
  end
endmodule

//--- sim/servo_gain_switch_selector_tb.sv
// Self-checking bench of the gain set selector
`timescale 1ns/1ps
module servo_gain_switch_selector_tb import sgsw_pkg::*; ;
  typedef struct packed {
    logic [8:0]  ctrl;
    sgsw_ctl_t   ctl;
    logic        gin;
    logic [2:0]  idx;
    logic [31:0] val;
    logic        exp;
  } sgsw_row_t;
  // Rows: CTRL value, control mode, gain input, loop quantity, value, expected gain
  localparam sgsw_row_t ROWS [17] = '{
    '{9'h100, SGSW_CTL_POS, 1'b0, 3'h1, 32'h000001F4, 1'b0},
    '{9'h101, SGSW_CTL_POS, 1'b0, 3'h7, 32'h00000000, 1'b1},
    '{9'h102, SGSW_CTL_POS, 1'b1, 3'h7, 32'h00000000, 1'b1},
    '{9'h102, SGSW_CTL_POS, 1'b0, 3'h7, 32'h00000000, 1'b0},
    '{9'h002, SGSW_CTL_POS, 1'b1, 3'h7, 32'h00000000, 1'b0},
    '{9'h103, SGSW_CTL_TRQ, 1'b0, 3'h0, 32'h00000079, 1'b1},
    '{9'h103, SGSW_CTL_POS, 1'b0, 3'h0, 32'hFFFFFF88, 1'b0},
    '{9'h105, SGSW_CTL_POS, 1'b0, 3'h1, 32'hFFFFFF87, 1'b1},
    '{9'h106, SGSW_CTL_POS, 1'b0, 3'h3, 32'h00000079, 1'b1},
    '{9'h106, SGSW_CTL_POS, 1'b0, 3'h4, 32'h00001388, 1'b0},
    '{9'h106, SGSW_CTL_FCL, 1'b0, 3'h4, 32'h00000079, 1'b1},
    '{9'h107, SGSW_CTL_FCL, 1'b0, 3'h5, 32'h00000001, 1'b1},
    '{9'h108, SGSW_CTL_POS, 1'b0, 3'h6, 32'h00000000, 1'b1},
    '{9'h109, SGSW_CTL_POS, 1'b0, 3'h2, 32'h00000079, 1'b1},
    '{9'h10A, SGSW_CTL_POS, 1'b0, 3'h5, 32'hFFFFFFFF, 1'b1},
    '{9'h105, SGSW_CTL_VEL, 1'b0, 3'h1, 32'h000001F4, 1'b0},
    '{9'h104, SGSW_CTL_POS, 1'b0, 3'h1, 32'h000001F4, 1'b0}
  };
  logic        clk_i;
  logic        reset_i;
  logic        ce_i;
  sgsw_ctl_t   ctl;
  logic        gin;
  sgsw_loop_t  tgt;
  sgsw_loop_t  loop;
  logic        second_gain_o;
  logic [7:0]  awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [7:0]  araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  int          errors;
  int          comparisons;

  sgsw_loop_model partner (.clk_i(clk_i), .reset_i(reset_i), .target_i(tgt), .loop_o(loop));
  sgsw_selector uut (
    .clk_i(clk_i), .reset_i(reset_i), .ce_i(ce_i), .loop_i(loop), .ctl_mode_i(ctl),
    .gain_in_i(gin), .second_gain_o(second_gain_o),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready)
  );

  initial clk_i = 1'b0;
  always #20 clk_i = ~clk_i;

  function automatic sgsw_loop_t mk(input logic [2:0] idx, input logic [31:0] v);
    sgsw_loop_t l;
    l       = '0;
    l.inpos = 1'b1;
    case (idx)
      3'h0: l.torque_cmd = v[15:0];
      3'h1: l.speed_cmd = v;
      3'h2: l.speed_act = v;
      3'h3: l.dev_encoder = v;
      3'h4: l.dev_scale = v;
      3'h5: l.pos_cmd = v;
      3'h6: l.inpos = 1'b0;
      default: ;
    endcase
    return l;
  endfunction

  task automatic summarize;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Master holds each channel until its own handshake edge
  task automatic wchk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_hit;
    logic w_hit;
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done  = 1'b0;
    @(posedge clk_i);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(negedge clk_i);
      aw_hit = awvalid & (awready === 1'b1);
      w_hit  = wvalid & (wready === 1'b1);
      @(posedge clk_i);
      if (aw_hit) awvalid <= 1'b0;
      if (w_hit) wvalid <= 1'b0;
      aw_done = aw_done | aw_hit;
      w_done  = w_done | w_hit;
    end
    do @(negedge clk_i); while (bvalid !== 1'b1);
    chk({30'h0, bresp}, {30'h0, er});
    @(posedge clk_i);
    bready <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic hit;
    hit = 1'b0;
    @(posedge clk_i);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (!hit) begin
      @(negedge clk_i);
      hit = (arready === 1'b1);
      @(posedge clk_i);
      if (hit) arvalid <= 1'b0;
    end
    do @(negedge clk_i); while (rvalid !== 1'b1);
    chk(rdata, ed);
    chk({30'h0, rresp}, {30'h0, er});
    @(posedge clk_i);
    rready <= 1'b0;
  endtask

  task automatic put(input logic [2:0] idx, input logic [31:0] v);
    @(posedge clk_i);
    tgt <= mk(idx, v);
  endtask

  task automatic gchk(input int n, input logic e);
    repeat (n) @(posedge clk_i);
    @(negedge clk_i);
    chk({31'h0, second_gain_o}, {31'h0, e});
  endtask

  initial begin
    reset_i = 1'b1;
    ce_i    = 1'b1;
    ctl     = SGSW_CTL_POS;
    gin     = 1'b0;
    tgt     = mk(3'h7, 32'h0);
    {awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
    repeat (10) @(posedge clk_i);
    reset_i <= 1'b0;
    wchk(ADDR_LEVEL, 32'h64, RESP_OKAY);
    wchk(ADDR_HYST, 32'h14, RESP_OKAY);
    wchk(ADDR_DELAY, 32'h0, RESP_OKAY);
    foreach (ROWS[i]) begin
      wchk(ADDR_CTRL, 32'h100, RESP_OKAY);
      @(posedge clk_i);
      tgt <= mk(ROWS[i].idx, ROWS[i].val);
      ctl <= ROWS[i].ctl;
      gin <= ROWS[i].gin;
      wchk(ADDR_CTRL, {23'h0, ROWS[i].ctrl}, RESP_OKAY);
      gchk(4, ROWS[i].exp);
    end
    // Hysteresis band edges with no return delay
    wchk(ADDR_CTRL, 32'h105, RESP_OKAY);
    put(3'h1, 32'h79);
    gchk(3, 1'b1);
    put(3'h1, 32'h50);
    gchk(20, 1'b1);
    put(3'h1, 32'h4F);
    gchk(3, 1'b0);
    // Hysteresis above level is clipped, so the thresholds are 20 and zero
    put(3'h1, 32'h0);
    wchk(ADDR_LEVEL, 32'h0A, RESP_OKAY);
    wchk(ADDR_HYST, 32'h32, RESP_OKAY);
    put(3'h1, 32'h15);
    gchk(3, 1'b1);
    put(3'h1, 32'h0);
    gchk(20, 1'b1);
    wchk(ADDR_LEVEL, 32'h64, RESP_OKAY);
    wchk(ADDR_HYST, 32'h14, RESP_OKAY);
    // One tick of delay, interrupted once mid-count
    wchk(ADDR_DELAY, 32'h1, RESP_OKAY);
    wchk(ADDR_CTRL, 32'h107, RESP_OKAY);
    put(3'h5, 32'h5);
    gchk(3, 1'b1);
    put(3'h5, 32'h0);
    repeat (1500) @(posedge clk_i);
    put(3'h5, 32'h5);
    put(3'h5, 32'h0);
    gchk(2400, 1'b1);
    gchk(150, 1'b0);
    // Return needs both a zero command and a slow axis; a low enable freezes the gain
    wchk(ADDR_DELAY, 32'h0, RESP_OKAY);
    wchk(ADDR_CTRL, 32'h10A, RESP_OKAY);
    put(3'h5, 32'h5);
    ce_i <= 1'b0;
    gchk(5, 1'b0);
    @(posedge clk_i);
    ce_i <= 1'b1;
    gchk(3, 1'b1);
    put(3'h2, 32'h1F4);
    gchk(20, 1'b1);
    put(3'h2, 32'h0);
    gchk(3, 1'b0);
    // Saturation, unmapped and read-only places
    wchk(ADDR_DELAY, 32'hFFFF, RESP_OKAY);
    rchk(ADDR_DELAY, 32'h2710, RESP_OKAY);
    wchk(ADDR_LEVEL, 32'h7530, RESP_OKAY);
    rchk(ADDR_LEVEL, 32'h4E20, RESP_OKAY);
    wchk(ADDR_HYST, 32'h7530, RESP_OKAY);
    rchk(ADDR_HYST, 32'h4E20, RESP_OKAY);
    wchk(8'h14, 32'h1, RESP_SLVERR);
    rchk(8'h14, 32'h0, RESP_SLVERR);
    wchk(ADDR_STATUS, 32'h1, RESP_OKAY);
    // Second reset from the second gain
    wchk(ADDR_CTRL, 32'h1, RESP_OKAY);
    gchk(3, 1'b1);
    rchk(ADDR_STATUS, 32'h1, RESP_OKAY);
    @(posedge clk_i);
    reset_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    reset_i <= 1'b0;
    gchk(0, 1'b0);
    rchk(ADDR_CTRL, 32'h0, RESP_OKAY);
    rchk(ADDR_DELAY, 32'h0A, RESP_OKAY);
    rchk(ADDR_LEVEL, 32'h0, RESP_OKAY);
    rchk(ADDR_HYST, 32'h0, RESP_OKAY);
    summarize();
  end

  // Whole run is near 4500 cycles; a hang is ended by the 30000-cycle budget
  initial begin
    repeat (30000) @(posedge clk_i);
    errors++;
    summarize();
  end
endmodule
